// ==== design/pfir_map.vh ====
// Register map, field positions, reset values and timing constants of the
// fault interrupt register group. Included by the fault register module only.
`ifndef PFIR_MAP_VH
`define PFIR_MAP_VH

// Register offsets on the serial control port, eight-bit address space.
`define PFIR_THERMAL_SUPPLY_SENSE_ADDR 8'h07
`define PFIR_BUCK_FAULT_STATUS_ADDR 8'h08
`define PFIR_BUCK_FAULT_MASK_ADDR 8'h09
`define PFIR_BUCK_FAULT_SENSE_ADDR 8'h0A
`define PFIR_BOOST_OTP_STATUS_ADDR 8'h0E
`define PFIR_BOOST_OTP_MASK_ADDR 8'h0F
`define PFIR_BOOST_OTP_SENSE_ADDR 8'h10
`define PFIR_LDO_FAULT_STATUS_ADDR 8'h11
`define PFIR_LDO_FAULT_MASK_ADDR 8'h12
`define PFIR_LDO_FAULT_SENSE_ADDR 8'h13

// Field positions and widths.
`define PFIR_BUCK_COUNT 7
`define PFIR_LDO_COUNT 6
`define PFIR_BOOST_BIT 0
`define PFIR_FUSE_ERR_BIT 7
`define PFIR_THERM120_BIT 3
`define PFIR_THERM130_BIT 5
`define PFIR_FUSE_SUPPLY_BIT 7

// Reset values: flags and sense bits clear, masks set.
`define PFIR_FLAG_RESET 1'h0
`define PFIR_MASK_RESET 1'h1
`define PFIR_RDATA_RESET 8'h00

// Timing: clock rate, and debounce periods in tenths of a millisecond.
`define PFIR_CLK_MHZ 100
`define PFIR_OC_DB_MS10 80
`define PFIR_TH_DB_MS10 39
// One tick per microsecond; 100 microseconds per tenth of a millisecond.
`define PFIR_TICK_DIV (`PFIR_CLK_MHZ)
`define PFIR_OC_DB_TICKS (`PFIR_OC_DB_MS10 * 100)
`define PFIR_TH_DB_TICKS (`PFIR_TH_DB_MS10 * 100)

`endif

// ==== design/pfir_tick.v ====
// Divider that issues a one-cycle enable every DIV clock cycles.
// Assumes a single system clock and a synchronous active-high reset.
`timescale 1ns/1ps
module pfir_tick #(
    parameter DIV = 100
) (
    input wire sys_clk, // System clock.
    input wire rst, // Synchronous reset, active high.
    output reg tick // One-cycle enable pulse.
);
    reg [15:0] cnt_reg;

    // Free-running count; the tick marks the wrap so the rate is exact.
    always @(posedge sys_clk) begin
        if (rst) begin
            cnt_reg <= 16'h0000;
            tick <= 1'b0;
        end else if (cnt_reg == DIV[15:0] - 16'h0001) begin
            cnt_reg <= 16'h0000;
            tick <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + 16'h0001;
            tick <= 1'b0;
        end
    end
endmodule

// ==== design/pfir_debounce.v ====
// Per-channel debouncer: a filtered level follows the raw input only after
// the input has held a new value for DB_TICKS consecutive enable ticks.
// Assumes raw inputs synchronous to sys_clk and a tick from pfir_tick.
`timescale 1ns/1ps
module pfir_debounce #(
    parameter W = 1,
    parameter CNT_W = 16,
    parameter DB_TICKS = 8000
) (
    input wire sys_clk, // System clock.
    input wire rst, // Synchronous reset, active high.
    input wire tick, // Time-base enable pulse.
    input wire [W-1:0] din, // Raw event levels.
    output reg [W-1:0] filt, // Debounced levels.
    output reg [W-1:0] rise, // One-cycle pulse on debounced low-to-high.
    output reg [W-1:0] fall // One-cycle pulse on debounced high-to-low.
);
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_ch
            reg [CNT_W-1:0] cnt_reg;
            // Any return to the old level restarts the count, so the
            // event must be stable over the whole period.
            always @(posedge sys_clk) begin
                if (rst) begin
                    cnt_reg <= {CNT_W{1'b0}};
                    filt[i] <= 1'b0;
                    rise[i] <= 1'b0;
                    fall[i] <= 1'b0;
                end else begin
                    rise[i] <= 1'b0;
                    fall[i] <= 1'b0;
                    if (din[i] == filt[i]) begin
                        cnt_reg <= {CNT_W{1'b0}};
                    end else if (tick) begin
                        if (cnt_reg == DB_TICKS[CNT_W-1:0] - 1'b1) begin
                            cnt_reg <= {CNT_W{1'b0}};
                            filt[i] <= din[i];
                            rise[i] <= din[i];
                            fall[i] <= ~din[i];
                        end else begin
                            cnt_reg <= cnt_reg + 1'b1;
                        end
                    end
                end
            end
        end
    endgenerate
endmodule

// ==== design/pfir_fault_regs.v ====
// Fault interrupt flag, mask and sense registers of the power device:
// buck, boost, linear regulator and fuse error flags, thermal and fuse
// supply sense bits, and the active-low interrupt output.
// Assumes a host register port with one-cycle read and write strobes,
// and raw fault levels already synchronous to sys_clk.
//
// Contract
// R1: Seven buck flags, bits 0-6, write-one-clear.
// R2: Buck mask bits reset to one, read-write.
// R3: Buck sense bits show live overcurrent.
// R4: Boost flag bit 0, fuse flag bit 7.
// R5: Boost and fuse masks reset one; 1-6 unused.
// R6: Boost and fuse error live sense bits.
// R7: Six linear flags bits 0-5, write-one-clear.
// R8: Linear mask bits 0-5 reset to one.
// R9: Linear sense bits 0-5 show overcurrent.
// R10: Thermal 120/125/130 sense at bits 3-5.
// R11: Fuse supply sense at bit 7.
// R12: Flags set only after stable debounce.
// R13: Overcurrent flags set on rise, 8.0 ms.
// R14: Thermal events on either edge, 3.9 ms.
// R15: Interrupt low while unmasked flag set.
// R16: Unused bits read zero, ignore writes.
`timescale 1ns/1ps
`include "pfir_map.vh"
module pfir_fault_regs #(
    parameter TICK_DIV = `PFIR_TICK_DIV,
    parameter OC_DB_TICKS = `PFIR_OC_DB_TICKS,
    parameter TH_DB_TICKS = `PFIR_TH_DB_TICKS
) (
    input wire sys_clk, // System clock, 100 MHz.
    input wire rst, // Synchronous reset, active high.
    input wire [7:0] reg_addr, // Register address from the serial port.
    input wire [7:0] reg_wdata, // Write data.
    input wire reg_wr_en, // One-cycle write strobe.
    input wire reg_rd_en, // One-cycle read strobe.
    output reg [7:0] reg_rdata, // Read data, valid the cycle after reg_rd_en.
    input wire [6:0] buck_oc_raw, // Buck overcurrent conditions.
    input wire boost_oc_raw, // Boost regulator overcurrent condition.
    input wire [5:0] ldo_oc_raw, // Linear regulator overcurrent conditions.
    input wire fuse_ecc_raw, // Fuse memory error detected.
    input wire [2:0] thermal_raw, // Thermal 120, 125, 130 degree comparators.
    input wire fuse_supply_raw, // Fuse programming supply pin at logic level.
    output reg interrupt_out_n, // Interrupt request, active low.
    output reg [2:0] thermal_event // Pulse per thermal edge, for the flag logic.
);

    // Address match, used by the write strobe decode; the read multiplexer decodes with a case.
    function pfir_hit;
        input [7:0] addr;
        input [7:0] target;
        begin
            pfir_hit = (addr == target);
        end
    endfunction

    wire tick;
    wire [14:0] oc_filt;
    wire [14:0] oc_rise;
    wire [2:0] th_filt;
    wire [2:0] th_rise;
    wire [2:0] th_fall;

    reg [6:0] buck_stat_reg;
    reg [6:0] buck_stat_next;
    reg [6:0] buck_mask_reg;
    reg [6:0] buck_sense_reg;
    reg boost_stat_reg;
    reg boost_stat_next;
    reg fuse_stat_reg;
    reg fuse_stat_next;
    reg boost_mask_reg;
    reg fuse_mask_reg;
    reg boost_sense_reg;
    reg fuse_sense_reg;
    reg [5:0] ldo_stat_reg;
    reg [5:0] ldo_stat_next;
    reg [5:0] ldo_mask_reg;
    reg [5:0] ldo_sense_reg;
    reg fuse_supply_reg;
    reg [7:0] rdata_next;
    reg irq_pending;

    // Write strobes, one per writable register.
    wire wr_buck_stat = reg_wr_en & pfir_hit(reg_addr, `PFIR_BUCK_FAULT_STATUS_ADDR);
    wire wr_buck_mask = reg_wr_en & pfir_hit(reg_addr, `PFIR_BUCK_FAULT_MASK_ADDR);
    wire wr_bo_stat = reg_wr_en & pfir_hit(reg_addr, `PFIR_BOOST_OTP_STATUS_ADDR);
    wire wr_bo_mask = reg_wr_en & pfir_hit(reg_addr, `PFIR_BOOST_OTP_MASK_ADDR);
    wire wr_ldo_stat = reg_wr_en & pfir_hit(reg_addr, `PFIR_LDO_FAULT_STATUS_ADDR);
    wire wr_ldo_mask = reg_wr_en & pfir_hit(reg_addr, `PFIR_LDO_FAULT_MASK_ADDR);

    // One microsecond time base for all debounce counters.
    pfir_tick #(
        .DIV(TICK_DIV)
    ) u_tick (
        .sys_clk(sys_clk),
        .rst(rst),
        .tick(tick)
    );

    // Overcurrent and fuse error channels share one 8.0 ms debounce.
    // Channel order: buck 0-6, boost 7, linear 8-13, fuse error 14.
    pfir_debounce #(
        .W(15),
        .CNT_W(16),
        .DB_TICKS(OC_DB_TICKS)
    ) u_oc_db (
        .sys_clk(sys_clk),
        .rst(rst),
        .tick(tick),
        .din({fuse_ecc_raw, ldo_oc_raw, boost_oc_raw, buck_oc_raw}),
        .filt(oc_filt),
        .rise(oc_rise),
        .fall()
    );

    // Thermal comparators debounce over 3.9 ms in both directions.
    pfir_debounce #(
        .W(3),
        .CNT_W(16),
        .DB_TICKS(TH_DB_TICKS)
    ) u_th_db (
        .sys_clk(sys_clk),
        .rst(rst),
        .tick(tick),
        .din(thermal_raw),
        .filt(th_filt),
        .rise(th_rise),
        .fall(th_fall)
    );

    // Flag update: a debounced rising edge sets, a written one clears.
    // The set term is ORed last so an edge in the clearing cycle survives.
    always @* begin
        buck_stat_next = buck_stat_reg; // R1
        if (wr_buck_stat) begin
            buck_stat_next = buck_stat_reg & ~reg_wdata[6:0]; // R1
        end
        buck_stat_next = buck_stat_next | oc_rise[6:0]; // R13

        boost_stat_next = boost_stat_reg;
        fuse_stat_next = fuse_stat_reg;
        if (wr_bo_stat) begin
            boost_stat_next = boost_stat_reg & ~reg_wdata[`PFIR_BOOST_BIT]; // R4
            fuse_stat_next = fuse_stat_reg & ~reg_wdata[`PFIR_FUSE_ERR_BIT]; // R4
        end
        boost_stat_next = boost_stat_next | oc_rise[7]; // R13
        fuse_stat_next = fuse_stat_next | oc_rise[14]; // R12

        ldo_stat_next = ldo_stat_reg;
        if (wr_ldo_stat) begin
            ldo_stat_next = ldo_stat_reg & ~reg_wdata[5:0]; // R7
        end
        ldo_stat_next = ldo_stat_next | oc_rise[13:8]; // R13
    end

    // Latched flags. Only debounced edges reach them, never raw levels.
    always @(posedge sys_clk) begin
        if (rst) begin
            buck_stat_reg <= {7{`PFIR_FLAG_RESET}};
            boost_stat_reg <= `PFIR_FLAG_RESET;
            fuse_stat_reg <= `PFIR_FLAG_RESET;
            ldo_stat_reg <= {6{`PFIR_FLAG_RESET}};
        end else begin
            buck_stat_reg <= buck_stat_next; // R12
            boost_stat_reg <= boost_stat_next;
            fuse_stat_reg <= fuse_stat_next;
            ldo_stat_reg <= ldo_stat_next;
        end
    end

    // Mask registers. Out of reset every source is masked, so the host
    // must unmask explicitly; stray faults at power-up raise nothing.
    always @(posedge sys_clk) begin
        if (rst) begin
            buck_mask_reg <= {7{`PFIR_MASK_RESET}}; // R2
            boost_mask_reg <= `PFIR_MASK_RESET; // R5
            fuse_mask_reg <= `PFIR_MASK_RESET; // R5
            ldo_mask_reg <= {6{`PFIR_MASK_RESET}}; // R8
        end else begin
            if (wr_buck_mask) begin
                buck_mask_reg <= reg_wdata[6:0]; // R2
            end
            if (wr_bo_mask) begin
                boost_mask_reg <= reg_wdata[`PFIR_BOOST_BIT]; // R5
                fuse_mask_reg <= reg_wdata[`PFIR_FUSE_ERR_BIT]; // R5
            end
            if (wr_ldo_mask) begin
                ldo_mask_reg <= reg_wdata[5:0]; // R8
            end
        end
    end

    // Sense bits follow the raw conditions with one register stage, so
    // software sees the live state, not the debounced one.
    always @(posedge sys_clk) begin
        if (rst) begin
            buck_sense_reg <= 7'h00;
            boost_sense_reg <= 1'b0;
            fuse_sense_reg <= 1'b0;
            ldo_sense_reg <= 6'h00;
            fuse_supply_reg <= 1'b0;
        end else begin
            buck_sense_reg <= buck_oc_raw; // R3
            boost_sense_reg <= boost_oc_raw; // R6
            fuse_sense_reg <= fuse_ecc_raw; // R6
            ldo_sense_reg <= ldo_oc_raw; // R9
            fuse_supply_reg <= fuse_supply_raw; // R11
        end
    end

    // Read multiplexer. Unused bits and unmapped addresses read zero.
    always @* begin
        rdata_next = `PFIR_RDATA_RESET;
        case (reg_addr)
            `PFIR_THERMAL_SUPPLY_SENSE_ADDR: begin
                rdata_next[`PFIR_THERM130_BIT:`PFIR_THERM120_BIT] = th_filt; // R10
                rdata_next[`PFIR_FUSE_SUPPLY_BIT] = fuse_supply_reg; // R11
            end
            `PFIR_BUCK_FAULT_STATUS_ADDR: begin
                rdata_next = {1'b0, buck_stat_reg}; // R16
            end
            `PFIR_BUCK_FAULT_MASK_ADDR: begin
                rdata_next = {1'b0, buck_mask_reg}; // R16
            end
            `PFIR_BUCK_FAULT_SENSE_ADDR: begin
                rdata_next = {1'b0, buck_sense_reg}; // R3
            end
            `PFIR_BOOST_OTP_STATUS_ADDR: begin
                rdata_next = {fuse_stat_reg, 6'h00, boost_stat_reg}; // R16
            end
            `PFIR_BOOST_OTP_MASK_ADDR: begin
                rdata_next = {fuse_mask_reg, 6'h00, boost_mask_reg}; // R5
            end
            `PFIR_BOOST_OTP_SENSE_ADDR: begin
                rdata_next = {fuse_sense_reg, 6'h00, boost_sense_reg}; // R6
            end
            `PFIR_LDO_FAULT_STATUS_ADDR: begin
                rdata_next = {2'h0, ldo_stat_reg}; // R7
            end
            `PFIR_LDO_FAULT_MASK_ADDR: begin
                rdata_next = {2'h0, ldo_mask_reg}; // R8
            end
            `PFIR_LDO_FAULT_SENSE_ADDR: begin
                rdata_next = {2'h0, ldo_sense_reg}; // R9
            end
            default: begin
                rdata_next = `PFIR_RDATA_RESET; // R16
            end
        endcase
    end

    // Read data is captured on the strobe and held until the next read,
    // which lets a slow serial shifter take it at leisure.
    always @(posedge sys_clk) begin
        if (rst) begin
            reg_rdata <= `PFIR_RDATA_RESET;
        end else if (reg_rd_en) begin
            reg_rdata <= rdata_next;
        end
    end

    // Any flag set with its mask clear requests an interrupt.
    always @* begin
        irq_pending = (|(buck_stat_reg & ~buck_mask_reg))
            | (boost_stat_reg & ~boost_mask_reg)
            | (fuse_stat_reg & ~fuse_mask_reg)
            | (|(ldo_stat_reg & ~ldo_mask_reg));
    end

    // Registered output: one cycle behind the flags, glitch free.
    always @(posedge sys_clk) begin
        if (rst) begin
            interrupt_out_n <= 1'b1;
        end else begin
            interrupt_out_n <= ~irq_pending; // R15
        end
    end

    // Thermal edges after debounce, either direction, handed to the flag
    // register that lives with the first status group.
    always @(posedge sys_clk) begin
        if (rst) begin
            thermal_event <= 3'h0;
        end else begin
            thermal_event <= th_rise | th_fall; // R14
        end
    end
endmodule

// ==== dv/pfir_fault_regs_properties.sv ====
// Checker for the fault interrupt register group, on top-level ports only.
// Assumes one-cycle host strobes and raw fault levels synchronous to sys_clk.
`timescale 1ns/1ps
module pfir_checker (
    input wire sys_clk, // System clock.
    input wire rst, // Synchronous reset, active high.
    input wire [7:0] reg_addr, // Register address.
    input wire [7:0] reg_wdata, // Write data.
    input wire reg_wr_en, // Write strobe.
    input wire reg_rd_en, // Read strobe.
    input wire [7:0] reg_rdata, // Read data.
    input wire [6:0] buck_oc_raw, // Buck overcurrent levels.
    input wire boost_oc_raw, // Boost overcurrent level.
    input wire [5:0] ldo_oc_raw, // Linear regulator overcurrent levels.
    input wire fuse_ecc_raw, // Fuse error level.
    input wire [2:0] thermal_raw, // Thermal comparators.
    input wire fuse_supply_raw, // Fuse supply level.
    input wire interrupt_out_n, // Interrupt, active low.
    input wire [2:0] thermal_event // Thermal edge pulses.
);
    // One domain, so clock and reset are given once for every property.
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    // Sense reads only hold while the raw level was steady into the read edge.
    property p_w1c;
        (reg_wr_en && reg_addr == 8'h08 && reg_wdata == 8'h7F && buck_oc_raw == 7'h00)
            ##2 (reg_rd_en && reg_addr == 8'h08) |=> reg_rdata == 8'h00;
    endproperty
    a_w1c: assert property (p_w1c) else $error("buck flags survived a full clear");
    property p_mask_buck;
        (reg_wr_en && reg_addr == 8'h09) ##2 (reg_rd_en && reg_addr == 8'h09)
            |=> reg_rdata == ($past(reg_wdata, 3) & 8'h7F);
    endproperty
    a_mask_buck: assert property (p_mask_buck) else $error("buck mask readback");
    property p_mask_boost;
        (reg_wr_en && reg_addr == 8'h0F) ##2 (reg_rd_en && reg_addr == 8'h0F)
            |=> reg_rdata == ($past(reg_wdata, 3) & 8'h81);
    endproperty
    a_mask_boost: assert property (p_mask_boost) else $error("boost mask readback");
    property p_sense_buck;
        reg_rd_en && reg_addr == 8'h0A && $stable(buck_oc_raw)
            |=> reg_rdata == {1'b0, $past(buck_oc_raw)};
    endproperty
    a_sense_buck: assert property (p_sense_buck) else $error("buck sense");
    property p_sense_boost;
        reg_rd_en && reg_addr == 8'h10 && $stable({fuse_ecc_raw, boost_oc_raw})
            |=> reg_rdata == {$past(fuse_ecc_raw), 6'h00, $past(boost_oc_raw)};
    endproperty
    a_sense_boost: assert property (p_sense_boost) else $error("boost sense");
    property p_sense_ldo;
        reg_rd_en && reg_addr == 8'h13 && $stable(ldo_oc_raw)
            |=> reg_rdata == {2'b00, $past(ldo_oc_raw)};
    endproperty
    a_sense_ldo: assert property (p_sense_ldo) else $error("ldo sense");
    property p_supply;
        reg_rd_en && reg_addr == 8'h07 && $stable(fuse_supply_raw)
            |=> reg_rdata[7] == $past(fuse_supply_raw) && reg_rdata[2:0] == 3'h0 && !reg_rdata[6];
    endproperty
    a_supply: assert property (p_supply) else $error("supply sense");
    property p_therm_db;
        $changed(thermal_raw) |=> (thermal_event == 3'h0) [*4];
    endproperty
    a_therm_db: assert property (p_therm_db) else $error("thermal edge too soon");
    property p_int_idle;
        $fell(rst) |-> interrupt_out_n [*4];
    endproperty
    a_int_idle: assert property (p_int_idle) else $error("interrupt out of reset");
    property p_unmapped;
        reg_rd_en && reg_addr == 8'h20 |=> reg_rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read");

    c_int: cover property ($fell(interrupt_out_n));
    c_therm: cover property (thermal_event != 3'h0);
    c_w1c: cover property (p_w1c);
endmodule

bind pfir_fault_regs pfir_checker u_checker (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata),
    .buck_oc_raw(buck_oc_raw), .boost_oc_raw(boost_oc_raw), .ldo_oc_raw(ldo_oc_raw),
    .fuse_ecc_raw(fuse_ecc_raw), .thermal_raw(thermal_raw), .fuse_supply_raw(fuse_supply_raw),
    .interrupt_out_n(interrupt_out_n), .thermal_event(thermal_event));

// ==== dv/pfir_host_model.sv ====
// Host processor side of the register port: single-byte reads and writes.
// Assumes it is called at a falling edge; strobes last one clock each.
`timescale 1ns/1ps
module pfir_host_model (
    input wire sys_clk, // System clock.
    output logic [7:0] reg_addr, // Register address.
    output logic [7:0] reg_wdata, // Write data.
    output logic reg_wr_en, // Write strobe.
    output logic reg_rd_en, // Read strobe.
    input wire [7:0] reg_rdata // Read data.
);
    // Idle bus from time zero so nothing is strobed during reset.
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
    end

    // The address is scrambled once released, so a stale value never helps.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr_en = 1'b1;
        @(negedge sys_clk);
        reg_wr_en = 1'b0;
        reg_addr = ~a;
        @(negedge sys_clk);
    endtask

    // Data is taken a cycle and a half after the read edge, where it stands.
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        reg_addr = a;
        reg_rd_en = 1'b1;
        @(negedge sys_clk);
        reg_rd_en = 1'b0;
        reg_addr = ~a;
        @(negedge sys_clk);
        d = reg_rdata;
    endtask
endmodule

// ==== dv/pfir_fault_regs_bench.sv ====
// Self-checking bench for the fault interrupt register group.
// Assumes short debounce parameters; the host model drives the port.
`timescale 1ns/1ps
`define CHK(g, e) \
    begin \
        n_compared++; \
        if ((g) !== (e)) begin \
            num_errors++; \
            $display("FAIL t=%0t got=%h exp=%h", $time, (g), (e)); \
        end \
    end
module pfir_fault_regs_bench;
    localparam int TDIV = 2;
    localparam int OCDB = 4;
    localparam int THDB = 3;
    // Slack beyond the longest debounce covers tick phase and pipeline.
    localparam int DBW = (OCDB + 2) * TDIV + 4;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic reg_wr_en, reg_rd_en, interrupt_out_n;
    logic [6:0] buck_oc_raw = 7'h00;
    logic boost_oc_raw = 1'b0;
    logic [5:0] ldo_oc_raw = 6'h00;
    logic fuse_ecc_raw = 1'b0;
    logic [2:0] thermal_raw = 3'h0;
    logic fuse_supply_raw = 1'b0;
    logic [2:0] thermal_event;
    int num_errors = 0;
    int n_compared = 0;
    int ev_count = 0;

    pfir_fault_regs #(.TICK_DIV(TDIV), .OC_DB_TICKS(OCDB), .TH_DB_TICKS(THDB)) dut (
        .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata),
        .buck_oc_raw(buck_oc_raw), .boost_oc_raw(boost_oc_raw), .ldo_oc_raw(ldo_oc_raw),
        .fuse_ecc_raw(fuse_ecc_raw), .thermal_raw(thermal_raw),
        .fuse_supply_raw(fuse_supply_raw), .interrupt_out_n(interrupt_out_n),
        .thermal_event(thermal_event));
    pfir_host_model host (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata));

    // 100 MHz clock.
    always #5 sys_clk = ~sys_clk;

    // Thermal pulses are tallied, since a missed falling edge is otherwise silent.
    always @(posedge sys_clk) ev_count <= ev_count + $countones(thermal_event);

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        host.rd(a, d);
        `CHK(d, e)
    endtask

    task automatic settle();
        repeat (DBW) @(negedge sys_clk);
    endtask

    task automatic t_reset_values();
        logic [7:0] ad [10] = '{8'h08, 8'h09, 8'h0A, 8'h0E, 8'h0F, 8'h10, 8'h11, 8'h12, 8'h13, 8'h07};
        logic [7:0] ex [10] = '{8'h00, 8'h7F, 8'h00, 8'h00, 8'h81, 8'h00, 8'h00, 8'h3F, 8'h00, 8'h00};
        `CHK(interrupt_out_n, 1'b1)
        for (int i = 0; i < 10; i++) begin
            rd_chk(ad[i], ex[i]);
        end
    endtask

    task automatic t_unused_bits();
        logic [7:0] ad [5] = '{8'h09, 8'h0F, 8'h12, 8'h0A, 8'h20};
        logic [7:0] ex [5] = '{8'h7F, 8'h81, 8'h3F, 8'h00, 8'h00};
        for (int i = 0; i < 5; i++) begin
            host.wr(ad[i], 8'hFF);
            rd_chk(ad[i], ex[i]);
        end
        for (int i = 0; i < 3; i++) begin
            host.wr(ad[i], 8'h00);
            rd_chk(ad[i], 8'h00);
        end
    endtask

    task automatic t_faults();
        buck_oc_raw = 7'h55;
        ldo_oc_raw = 6'h2A;
        boost_oc_raw = 1'b1;
        fuse_ecc_raw = 1'b1;
        fuse_supply_raw = 1'b1;
        @(negedge sys_clk);
        rd_chk(8'h0A, 8'h55);
        rd_chk(8'h13, 8'h2A);
        rd_chk(8'h10, 8'h81);
        rd_chk(8'h07, 8'h80);
        settle();
        `CHK(interrupt_out_n, 1'b0)
        rd_chk(8'h08, 8'h55);
        rd_chk(8'h11, 8'h2A);
        rd_chk(8'h0E, 8'h81);
        buck_oc_raw = 7'h00;
        ldo_oc_raw = 6'h00;
        boost_oc_raw = 1'b0;
        fuse_ecc_raw = 1'b0;
        settle();
        host.wr(8'h08, 8'h01);
        rd_chk(8'h08, 8'h54);
        host.wr(8'h11, 8'h3F);
        host.wr(8'h0E, 8'hFF);
        host.wr(8'h08, 8'h7F);
        rd_chk(8'h08, 8'h00);
        rd_chk(8'h11, 8'h00);
        rd_chk(8'h0E, 8'h00);
        `CHK(interrupt_out_n, 1'b1)
    endtask

    task automatic t_glitch_and_mask();
        buck_oc_raw = 7'h01;
        repeat (2) @(negedge sys_clk);
        buck_oc_raw = 7'h00;
        settle();
        rd_chk(8'h08, 8'h00);
        host.wr(8'h09, 8'h7F);
        buck_oc_raw = 7'h40;
        settle();
        `CHK(interrupt_out_n, 1'b1)
        rd_chk(8'h08, 8'h40);
        host.wr(8'h09, 8'h00);
        `CHK(interrupt_out_n, 1'b0)
        buck_oc_raw = 7'h00;
        host.wr(8'h08, 8'h40);
        `CHK(interrupt_out_n, 1'b1)
    endtask

    task automatic t_thermal();
        int ev0;
        ev0 = ev_count;
        thermal_raw = 3'b101;
        settle();
        // The fuse supply input is still high from the fault scenario, so bit 7 reads one.
        rd_chk(8'h07, 8'hA8);
        thermal_raw = 3'b000;
        settle();
        rd_chk(8'h07, 8'h80);
        `CHK(ev_count - ev0, 4)
    endtask

    task automatic finish_test();
        if (num_errors == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Main sequence: three cycles of reset, then each scenario in turn.
    initial begin
        repeat (3) @(negedge sys_clk);
        rst = 1'b0;
        t_reset_values();
        t_unused_bits();
        t_faults();
        t_glitch_and_mask();
        t_thermal();
        finish_test();
    end

    // Watchdog, about twenty-five times the expected run length.
    initial begin
        #50000;
        num_errors++;
        finish_test();
    end
endmodule
